// *** hdl/bpfe_pkg.sv ***
// constants and types shared by the branch prediction front end
package bpfe_pkg;
    // address and micro-op widths
    localparam int ADDR_W = 32;
    localparam int UOP_W = 32;
    localparam int UOP_PER = 3;
    localparam int CNT_W = 2;
    localparam int OPS_W = UOP_PER * UOP_W;
    // return address stack: 16 entries
    localparam int RAS_N = 16;
    localparam int RAS_IW = 4;
    // target prediction table, direct mapped on the linear address
    localparam int TT_N = 64;
    localparam int TT_IW = 6;
    localparam int TT_TW = ADDR_W - TT_IW;
    // decoded op store: 4096 lines of three ops, 12288 ops in all
    localparam int SL_N = 4096;
    localparam int SL_IW = 12;
    localparam int SL_TW = ADDR_W - SL_IW;
    localparam int STORE_CAP = SL_N * UOP_PER;
    // payload of one delivery word: ops, count, rom flag, next address
    localparam int BUF_W = OPS_W + CNT_W + 1 + ADDR_W;
    // recovery penalty after a misprediction, in cycles of ref_clk
    localparam int PEN_W = 5;
    localparam logic [PEN_W-1:0] PEN_CYC = 5'h14;
    // reset address, new-entry counter values and counter limit
    localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0000_0000;
    localparam logic [1:0] CTR_WT = 2'h2;
    localparam logic [1:0] CTR_WN = 2'h1;
    localparam logic [1:0] CTR_MAX = 2'h3;
    // prediction source codes
    localparam logic [1:0] SRC_DYN = 2'h0;
    localparam logic [1:0] SRC_STAT = 2'h1;
    localparam logic [1:0] SRC_RET = 2'h2;

    // control transfer kinds reported by decode and retirement
    typedef enum logic [3:0] {
        K_NONE = 4'h0,
        K_COND = 4'h1,
        K_CALL = 4'h2,
        K_CCALL = 4'h3,
        K_RET = 4'h4,
        K_IND = 4'h5,
        K_FCALL = 4'h6,
        K_IRET = 4'h7,
        K_SWI = 4'h8
    } bpfe_kind_t;

    // front end mode
    typedef enum logic [1:0] {
        FE_RUN = 2'b01,
        FE_RECOV = 2'b10
    } bpfe_fe_t;
endpackage

// *** hdl/bpfe_pair_buf.sv ***
// two-entry valid/ready buffer on the micro-op delivery path
`timescale 1ns/100ps
module bpfe_pair_buf
    import bpfe_pkg::*;
#(
    parameter int W = BUF_W,
    parameter int D = 2
) (
    // clock, reset, freeze
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // drop contents, refuse input
    input wire logic flush,
    input wire logic block,
    // filling side
    input wire logic inValid,
    input wire logic [W-1:0] inData,
    output logic inReady,
    // draining side
    input wire logic outReady,
    output logic outValid,
    output logic [W-1:0] outData
);
    localparam int PW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic [PW:0] cnt_d;
    logic push;
    logic pop;

    assign push = inValid && inReady && !flush;
    assign pop = outValid && outReady && !flush;
    assign outData = mem_q[rd_q];

    // occupancy after this cycle
    always_comb begin
        cnt_d = cnt_q;
        if (flush) begin
            cnt_d = '0;
        end else if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // pointers and registered handshake flags
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            inReady <= 1'b1;
            outValid <= 1'b0;
        end else if (clkEn) begin
            cnt_q <= cnt_d;
            inReady <= !block && (cnt_d < (PW+1)'(D));
            outValid <= cnt_d != '0;
            if (flush) begin
                wr_q <= '0;
                rd_q <= '0;
            end else begin
                if (push) begin
                    wr_q <= (wr_q == PW'(D-1)) ? '0 : wr_q + 1'b1;
                end
                if (pop) begin
                    rd_q <= (rd_q == PW'(D-1)) ? '0 : rd_q + 1'b1;
                end
            end
        end
    end

    // entry storage
    always_ff @(posedge ref_clk) begin
        if (clkEn && push) begin
            mem_q[wr_q] <= inData;
        end
    end
endmodule

// *** hdl/bpfe_front_end.sv ***
// branch prediction front end with decoded op store delivery
`timescale 1ns/100ps
module bpfe_front_end
    import bpfe_pkg::*;
(
    // clock, reset and freeze
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // fetch-time lookup
    input wire logic fetchValid,
    input wire logic [ADDR_W-1:0] fetchAddr,
    output logic dynValid,
    output logic dynTaken,
    output logic [ADDR_W-1:0] dynTarget,
    // decode-time prediction
    input wire logic decValid,
    input wire bpfe_kind_t decKind,
    input wire logic [ADDR_W-1:0] decAddr,
    input wire logic [ADDR_W-1:0] decDisp,
    input wire logic [ADDR_W-1:0] decRetAddr,
    output logic decPredValid,
    output logic decPredTaken,
    output logic [ADDR_W-1:0] decPredTarget,
    output logic [1:0] decPredSrc,
    // retirement update
    input wire logic retValid,
    input wire bpfe_kind_t retKind,
    input wire logic [ADDR_W-1:0] retAddr,
    input wire logic retTaken,
    input wire logic [ADDR_W-1:0] retTarget,
    // misprediction from execution
    input wire logic mispValid,
    input wire logic [ADDR_W-1:0] mispTarget,
    output logic redirValid,
    output logic [ADDR_W-1:0] redirAddr,
    // trace fill from the translation engine
    input wire logic fillValid,
    input wire logic [ADDR_W-1:0] fillAddr,
    input wire logic [OPS_W-1:0] fillOps,
    input wire logic [CNT_W-1:0] fillCnt,
    input wire logic [ADDR_W-1:0] fillNext,
    // delivery request
    input wire logic opReqValid,
    input wire logic [ADDR_W-1:0] opReqAddr,
    input wire logic opReqRom,
    input wire logic [OPS_W-1:0] romOps,
    input wire logic [CNT_W-1:0] romCnt,
    output logic opReqReady,
    output logic opMiss,
    // delivery to the execution core
    input wire logic opReady,
    output logic opValid,
    output logic [OPS_W-1:0] opData,
    output logic [CNT_W-1:0] opCnt,
    output logic opFromRom,
    output logic [ADDR_W-1:0] opNext
);
    // target table storage
    logic ttVal_q [TT_N];
    logic [TT_TW-1:0] ttTag_q [TT_N];
    logic [ADDR_W-1:0] ttTgt_q [TT_N];
    logic [1:0] ttCtr_q [TT_N];
    // return stack storage
    logic [ADDR_W-1:0] ras_q [RAS_N];
    logic [RAS_IW-1:0] sp_q;
    logic [RAS_IW:0] rasDepth_q;
    logic [RAS_IW-1:0] topIdx;
    logic [ADDR_W-1:0] rasTop;
    // op store storage
    logic slVal_q [SL_N];
    logic [SL_TW-1:0] slTag_q [SL_N];
    logic [OPS_W-1:0] slOps_q [SL_N];
    logic [CNT_W-1:0] slCnt_q [SL_N];
    logic [ADDR_W-1:0] slNext_q [SL_N];
    // lookups
    logic [TT_IW-1:0] fIdx;
    logic [TT_IW-1:0] dIdx;
    logic [TT_IW-1:0] rIdx;
    logic fHit;
    logic dHit;
    logic rHit;
    logic rNear;
    logic [ADDR_W-1:0] fTgt;
    logic [1:0] ctr_d;
    // decode stage
    logic pv;
    logic pt;
    logic [ADDR_W-1:0] ptgt;
    logic [1:0] psrc;
    logic push;
    logic pop;
    // delivery
    logic [SL_IW-1:0] sIdx;
    logic [SL_IW-1:0] wIdx;
    logic sHit;
    logic bufIn;
    logic [BUF_W-1:0] bufData;
    logic [BUF_W-1:0] bufOut;
    // recovery sequencing
    bpfe_fe_t fe_q;
    bpfe_fe_t fe_d;
    logic [PEN_W-1:0] pen_q;
    logic [PEN_W-1:0] pen_d;

    // table lookups: fetch, decode and retire each index the table
    assign fIdx = fetchAddr[TT_IW-1:0];
    assign dIdx = decAddr[TT_IW-1:0];
    assign rIdx = retAddr[TT_IW-1:0];
    assign fHit = ttVal_q[fIdx] && ttTag_q[fIdx] == fetchAddr[ADDR_W-1:TT_IW];
    assign dHit = ttVal_q[dIdx] && ttTag_q[dIdx] == decAddr[ADDR_W-1:TT_IW];
    assign rHit = ttVal_q[rIdx] && ttTag_q[rIdx] == retAddr[ADDR_W-1:TT_IW];
    assign fTgt = ttTgt_q[fIdx];
    // only near non-return transfers enter the table
    assign rNear = retValid && (retKind == K_COND || retKind == K_CALL ||
        retKind == K_CCALL || retKind == K_IND);

    // fetch-time prediction, one cycle after the address
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dynValid <= 1'b0;
            dynTaken <= 1'b0;
            dynTarget <= RST_ADDR;
        end else if (clkEn) begin
            dynValid <= fetchValid && fHit;
            dynTaken <= fetchValid && fHit && ttCtr_q[fIdx][1];
            dynTarget <= fTgt;
        end
    end

    // history counter step for the retiring branch
    always_comb begin
        ctr_d = retTaken ? CTR_WT : CTR_WN;
        if (rHit) begin
            ctr_d = ttCtr_q[rIdx];
            if (retTaken && ttCtr_q[rIdx] != CTR_MAX) begin
                ctr_d = ttCtr_q[rIdx] + 2'h1;
            end else if (!retTaken && ttCtr_q[rIdx] != 2'h0) begin
                ctr_d = ttCtr_q[rIdx] - 2'h1;
            end
        end
    end

    // per-entry valid bits of the target table
    for (genvar g = 0; g < TT_N; g++) begin : g_ttv
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                ttVal_q[g] <= 1'b0;
            end else if (clkEn && rNear && rIdx == TT_IW'(g)) begin
                ttVal_q[g] <= 1'b1;
            end
        end
    end

    // retirement writes tag, resolved target and history
    always_ff @(posedge ref_clk) begin
        if (clkEn && rNear) begin
            ttTag_q[rIdx] <= retAddr[ADDR_W-1:TT_IW];
            ttTgt_q[rIdx] <= retTarget;
            ttCtr_q[rIdx] <= ctr_d;
        end
    end

    // decode-time prediction: static rule, calls and returns
    always_comb begin
        pv = 1'b0;
        pt = 1'b0;
        ptgt = decAddr + decDisp;
        psrc = SRC_STAT;
        push = 1'b0;
        pop = 1'b0;
        if (decValid) begin
            case (decKind)
                K_RET: begin
                    pv = 1'b1;
                    pt = 1'b1;
                    ptgt = rasTop;
                    psrc = SRC_RET;
                    pop = 1'b1;
                end
                K_CALL: begin
                    push = 1'b1;
                    pv = !dHit;
                    pt = 1'b1;
                end
                K_CCALL: begin
                    pt = dHit ? ttCtr_q[dIdx][1] : decDisp[ADDR_W-1];
                    push = pt;
                    pv = !dHit;
                end
                K_COND: begin
                    pv = !dHit;
                    pt = decDisp[ADDR_W-1];
                end
                default: begin
                    pv = 1'b0;
                end
            endcase
        end
    end

    // registered decode-time prediction
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            decPredValid <= 1'b0;
            decPredTaken <= 1'b0;
            decPredTarget <= RST_ADDR;
            decPredSrc <= SRC_DYN;
        end else if (clkEn) begin
            decPredValid <= pv;
            decPredTaken <= pv && pt;
            decPredTarget <= ptgt;
            decPredSrc <= psrc;
        end
    end

    // return stack: oldest entry is overwritten on wrap
    assign topIdx = sp_q - 1'b1;
    assign rasTop = ras_q[topIdx];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sp_q <= '0;
            rasDepth_q <= '0;
        end else if (clkEn) begin
            if (push) begin
                sp_q <= sp_q + 1'b1;
                if (rasDepth_q != (RAS_IW+1)'(RAS_N)) begin
                    rasDepth_q <= rasDepth_q + 1'b1;
                end
            end else if (pop) begin
                sp_q <= topIdx;
                if (rasDepth_q != '0) begin
                    rasDepth_q <= rasDepth_q - 1'b1;
                end
            end
        end
    end

    // return address entries
    always_ff @(posedge ref_clk) begin
        if (clkEn && push) begin
            ras_q[sp_q] <= decRetAddr;
        end
    end

    // op store lookup and fill indices
    assign sIdx = opReqAddr[SL_IW-1:0];
    assign wIdx = fillAddr[SL_IW-1:0];
    assign sHit = slVal_q[sIdx] &&
        slTag_q[sIdx] == opReqAddr[ADDR_W-1:SL_IW];

    // per-line valid bits of the op store, 4096 x 3 ops
    for (genvar g = 0; g < SL_N; g++) begin : g_slv
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                slVal_q[g] <= 1'b0;
            end else if (clkEn && fillValid && wIdx == SL_IW'(g)) begin
                slVal_q[g] <= 1'b1;
            end
        end
    end

    // trace line: ops across a taken branch plus its continuation
    always_ff @(posedge ref_clk) begin
        if (clkEn && fillValid) begin
            slTag_q[wIdx] <= fillAddr[ADDR_W-1:SL_IW];
            slOps_q[wIdx] <= fillOps;
            slCnt_q[wIdx] <= fillCnt;
            slNext_q[wIdx] <= fillNext;
        end
    end

    // rom flow takes the place of the stored trace when flagged
    always_comb begin
        if (opReqRom) begin
            bufData = {romOps, romCnt, 1'b1, opReqAddr};
        end else begin
            bufData = {slOps_q[sIdx], slCnt_q[sIdx], 1'b0, slNext_q[sIdx]};
        end
    end
    assign bufIn = opReqValid && (opReqRom || sHit);

    // miss pulse: the line must come from the memory hierarchy
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            opMiss <= 1'b0;
        end else if (clkEn) begin
            opMiss <= opReqValid && opReqReady && !opReqRom && !sHit &&
                !mispValid;
        end
    end

    // one delivery word per cycle, up to three ops
    bpfe_pair_buf #(
        .W(BUF_W),
        .D(2)
    ) u_buf (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .flush(mispValid),
        .block(fe_d == FE_RECOV),
        .inValid(bufIn),
        .inData(bufData),
        .inReady(opReqReady),
        .outReady(opReady),
        .outValid(opValid),
        .outData(bufOut)
    );
    assign {opData, opCnt, opFromRom, opNext} = bufOut;

    // recovery sequencing: requests refused for the penalty window
    always_comb begin
        fe_d = fe_q;
        pen_d = pen_q;
        if (mispValid) begin
            fe_d = FE_RECOV;
            pen_d = PEN_CYC;
        end else begin
            case (fe_q)
                FE_RUN: begin
                    pen_d = '0;
                end
                FE_RECOV: begin
                    pen_d = pen_q - 1'b1;
                    if (pen_q == 5'h01) begin
                        fe_d = FE_RUN;
                    end
                end
                default: begin
                    fe_d = FE_RUN;
                    pen_d = '0;
                end
            endcase
        end
    end

    // recovery state
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fe_q <= FE_RUN;
            pen_q <= '0;
        end else if (clkEn) begin
            fe_q <= fe_d;
            pen_q <= pen_d;
        end
    end

    // fetch redirect to the resolved target
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            redirValid <= 1'b0;
            redirAddr <= RST_ADDR;
        end else if (clkEn) begin
            redirValid <= mispValid;
            if (mispValid) begin
                redirAddr <= mispTarget;
            end
        end
    end

    // checks on the prediction and recovery behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst || !clkEn);

    property p_far_none;
        decValid && (decKind == K_FCALL || decKind == K_IRET ||
            decKind == K_SWI) |=> !decPredValid && !decPredTaken;
    endproperty
    a_far_none: assert property (p_far_none)
        else $error("far transfer got a prediction");

    property p_dyn_early;
        fetchValid && fHit |=> dynValid && dynTarget == $past(fTgt);
    endproperty
    a_dyn_early: assert property (p_dyn_early)
        else $error("table hit not predicted next cycle");

    property p_static_back;
        decValid && decKind == K_COND && !dHit && decDisp[ADDR_W-1]
            |=> decPredValid && decPredTaken && decPredSrc == SRC_STAT;
    endproperty
    a_static_back: assert property (p_static_back)
        else $error("backward branch not predicted taken");

    property p_static_fwd;
        decValid && decKind == K_COND && !dHit && !decDisp[ADDR_W-1]
            |=> decPredValid && !decPredTaken;
    endproperty
    a_static_fwd: assert property (p_static_fwd)
        else $error("forward branch predicted taken");

    property p_hit_no_static;
        decValid && decKind == K_COND && dHit |=> !decPredValid;
    endproperty
    a_hit_no_static: assert property (p_hit_no_static)
        else $error("static prediction despite table entry");

    property p_ret_taken;
        decValid && decKind == K_RET |=> decPredValid && decPredTaken &&
            decPredSrc == SRC_RET && decPredTarget == $past(rasTop);
    endproperty
    a_ret_taken: assert property (p_ret_taken)
        else $error("return not predicted from stack");

    property p_ras_push;
        push && rasDepth_q != (RAS_IW+1)'(RAS_N)
            |=> rasDepth_q == $past(rasDepth_q) + 5'h01;
    endproperty
    a_ras_push: assert property (p_ras_push)
        else $error("stack depth did not grow on call");

    property p_upd;
        rNear |=> ttVal_q[$past(rIdx)] &&
            ttTgt_q[$past(rIdx)] == $past(retTarget);
    endproperty
    a_upd: assert property (p_upd)
        else $error("table not updated by retirement");

    property p_redir;
        mispValid |=> redirValid && !opValid &&
            redirAddr == $past(mispTarget);
    endproperty
    a_redir: assert property (p_redir)
        else $error("misprediction not flushed and redirected");

    property p_pen;
        mispValid |=> (fe_q == FE_RECOV && !opReqReady) [*8];
    endproperty
    a_pen: assert property (p_pen)
        else $error("requests accepted during recovery");
endmodule

// *** tb/bpfe_core_side.sv ***
// retirement unit and execution core sink facing the front end
`timescale 1ns/100ps
module bpfe_core_side
    import bpfe_pkg::*;
(
    // retire command and core stall from the bench
    input wire logic cmdGo,
    input wire bpfe_kind_t cmdKind,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic cmdTaken,
    input wire logic [ADDR_W-1:0] cmdTarget,
    input wire logic stall,
    // retirement port and core acceptance
    output bpfe_kind_t retKind,
    output logic retValid,
    output logic [ADDR_W-1:0] retAddr,
    output logic retTaken,
    output logic [ADDR_W-1:0] retTarget,
    output logic opReady
);
    // one resolved branch a cycle; idle fields never hold the old value
    assign retValid = cmdGo;
    assign retKind = cmdGo ? cmdKind : K_NONE;
    assign retAddr = cmdGo ? cmdAddr : ~cmdAddr;
    assign retTaken = cmdGo ? cmdTaken : ~cmdTaken;
    assign retTarget = cmdGo ? cmdTarget : ~cmdTarget;
    // core takes a word whenever it is not stalled
    assign opReady = !stall;
endmodule

// *** tb/tb.sv ***
// self-checking bench for the branch prediction front end
`timescale 1ns/100ps
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin \
    errTotal++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb
    import bpfe_pkg::*;
;
    logic ref_clk, nrst, clkEn, fetchValid, dynValid, dynTaken, decValid;
    logic decPredValid, decPredTaken, mispValid, redirValid, fillValid;
    logic opReqValid, opReqRom, opReqReady, opMiss, opReady, opValid;
    logic opFromRom, cmdGo, cmdTaken, retValid, retTaken, stall = 1'b0;
    logic [ADDR_W-1:0] fetchAddr, dynTarget, decAddr, decDisp, decRetAddr;
    logic [ADDR_W-1:0] decPredTarget, mispTarget, redirAddr, fillAddr;
    logic [ADDR_W-1:0] fillNext, opReqAddr, opNext, cmdAddr, cmdTarget;
    logic [ADDR_W-1:0] retAddr, retTarget, r, a, sr, ladr[3], ras[$];
    logic [OPS_W-1:0] fillOps, romOps, opData;
    logic [CNT_W-1:0] fillCnt, romCnt, opCnt;
    logic [1:0] decPredSrc;
    logic [BUF_W-1:0] expQ[$], lines[3], w;
    logic [31:0] seed = 32'h0000_2C4C;
    logic [4:0] pat = 5'h19;
    bpfe_kind_t decKind, cmdKind, retKind;
    bpfe_kind_t nk[5] = '{K_NONE, K_IND, K_FCALL, K_IRET, K_SWI};
    int errTotal = 0, checksDone = 0, cyc = 0, stallMode = 0;
    int ctr, n, acc;

    // design and far-side model
    bpfe_front_end dut (.ref_clk, .nrst, .clkEn, .fetchValid,
        .fetchAddr, .dynValid, .dynTaken, .dynTarget, .decValid, .decKind,
        .decAddr, .decDisp, .decRetAddr, .decPredValid, .decPredTaken,
        .decPredTarget, .decPredSrc, .retValid, .retKind, .retAddr,
        .retTaken, .retTarget, .mispValid, .mispTarget, .redirValid,
        .redirAddr, .fillValid, .fillAddr, .fillOps, .fillCnt, .fillNext,
        .opReqValid, .opReqAddr, .opReqRom, .romOps, .romCnt, .opReqReady,
        .opMiss, .opReady, .opValid, .opData, .opCnt, .opFromRom, .opNext);
    bpfe_core_side core (.cmdGo, .cmdKind, .cmdAddr, .cmdTaken, .cmdTarget,
        .stall, .retKind, .retValid, .retAddr, .retTaken, .retTarget,
        .opReady);

    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic tick();
        @(negedge ref_clk);
    endtask

    task automatic done(string s);
        $display("test %s done", s);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic retire(bpfe_kind_t k, logic [31:0] ad, logic t,
        logic [31:0] tg);
        cmdGo = 1'b1;
        cmdKind = k;
        cmdAddr = ad;
        cmdTaken = t;
        cmdTarget = tg;
        tick();
        cmdGo = 1'b0;
    endtask

    task automatic lookup(logic [31:0] ad, logic v, t, logic [31:0] tg);
        fetchValid = 1'b1;
        fetchAddr = ad;
        tick();
        fetchValid = 1'b0;
        `CHK("dynValid", v, dynValid)
        if (v) `CHK("dynTaken", t, dynTaken)
        if (v) `CHK("dynTarget", tg, dynTarget)
    endtask

    // decode request stays raised; caller lowers it after a group
    task automatic decode(bpfe_kind_t k, logic [31:0] ad, d, ra);
        decValid = 1'b1;
        decKind = k;
        decAddr = ad;
        decDisp = d;
        decRetAddr = ra;
        tick();
    endtask

    task automatic expect_pred(logic v, t, logic [31:0] tg, logic [1:0] s);
        `CHK("decPredValid", v, decPredValid)
        `CHK("decPredTaken", v && t, decPredTaken)
        if (v && t) `CHK("decPredTarget", tg, decPredTarget)
        if (v) `CHK("decPredSrc", s, decPredSrc)
    endtask

    // held until ready: 0..2 stored line, 3 rom flow, 4 miss
    task automatic req(int i);
        r = rnd();
        opReqValid = 1'b1;
        opReqRom = (i == 3);
        opReqAddr = (i < 3) ? ladr[i] : {r[31:12], 12'hF00};
        romOps = {rnd(), rnd(), rnd()};
        romCnt = r[1:0] | 2'h1;
        n = 0;
        while (opReqReady !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        if (i < 3) expQ.push_back(lines[i]);
        if (i == 3) expQ.push_back({romOps, romCnt, 1'b1, opReqAddr});
        tick();
        `CHK("opMiss", i == 4, opMiss)
    endtask

    task automatic drain();
        stallMode = 2;
        n = 0;
        while (expQ.size() != 0 && n < 200) begin
            tick();
            n++;
        end
        `CHK("left", 0, expQ.size())
    endtask

    // core stall pattern: none, held, or random
    always @(negedge ref_clk) begin
        sr = rnd();
        stall <= (stallMode == 1) || (stallMode == 2 && sr[0]);
    end

    // word check at each core acceptance, and the run limit
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errTotal++;
            summarize();
        end
        if (nrst === 1'b1 && opValid === 1'b1 && opReady === 1'b1) begin
            w = (expQ.size() > 0) ? expQ.pop_front() : '0;
            `CHK("word", w, {opData, opCnt, opFromRom, opNext})
        end
    end

    // main sequence
    initial begin
        {nrst, fetchValid, decValid, mispValid, fillValid, opReqValid} = '0;
        {opReqRom, cmdGo, cmdTaken, fetchAddr, decAddr, decDisp} = '0;
        {decRetAddr, mispTarget, fillAddr, fillNext, opReqAddr} = '0;
        {cmdAddr, cmdTarget, fillOps, romOps, fillCnt, romCnt} = '0;
        decKind = K_NONE;
        cmdKind = K_NONE;
        clkEn = 1'b1;
        repeat (3) tick();
        nrst = 1'b1;
        tick();
        `CHK("opReqReady", 1'b1, opReqReady)
        done("reset");
        a = rnd();
        for (int i = 0; i < 5; i++) begin
            r = rnd();
            retire(K_COND, {a[31:6], 6'h05}, pat[i], r);
            if (i == 0) ctr = pat[i] ? 2 : 1;
            else if (pat[i]) ctr = (ctr == 3) ? 3 : ctr + 1;
            else ctr = (ctr == 0) ? 0 : ctr - 1;
            lookup({a[31:6], 6'h05}, 1'b1, ctr >= 2, r);
        end
        for (int k = 1; k < 9; k++) begin
            r = rnd();
            retire(bpfe_kind_t'(k), {a[31:6], 6'h10 + 6'(k)}, 1'b1, r);
            lookup({a[31:6], 6'h10 + 6'(k)}, k inside {1, 2, 3, 5}, 1'b1, r);
        end
        done("table");
        a = {a[31:6], 6'h2A};
        decode(K_COND, a, -32'h40, a);
        expect_pred(1'b1, 1'b1, a - 32'h40, SRC_STAT);
        decode(K_COND, a, 32'h40, a);
        expect_pred(1'b1, 1'b0, a, SRC_STAT);
        for (int i = 0; i < 5; i++) begin
            decode(nk[i], a, -32'h40, a);
            expect_pred(1'b0, 1'b0, a, SRC_STAT);
        end
        for (int i = 0; i < 17; i++) begin
            r = rnd();
            ras.push_back(r);
            if (ras.size() > RAS_N) ras.pop_front();
            decode(K_CALL, {a[31:6], 6'h30}, 32'h100, r);
            expect_pred(1'b1, 1'b1, {a[31:6], 6'h30} + 32'h100,
                SRC_STAT);
        end
        for (int i = 0; i < RAS_N; i++) begin
            decode(K_RET, a, 32'h0, 32'h0);
            expect_pred(1'b1, 1'b1, ras.pop_back(), SRC_RET);
        end
        // taken conditional call pushes, the next return pops it
        r = rnd();
        decode(K_CCALL, a, -32'h40, r);
        expect_pred(1'b1, 1'b1, a - 32'h40, SRC_STAT);
        decode(K_RET, a, 32'h0, 32'h0);
        expect_pred(1'b1, 1'b1, r, SRC_RET);
        // table entry present: no static prediction
        decode(K_COND, {a[31:6], 6'h05}, -32'h40, a);
        expect_pred(1'b0, 1'b0, a, SRC_STAT);
        decValid = 1'b0;
        done("decode");
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            fillAddr = {r[31:12], 12'h100 + 12'(i)};
            fillOps = {rnd(), rnd(), rnd()};
            fillCnt = 2'(i + 1);
            fillNext = rnd();
            lines[i] = {fillOps, fillCnt, 1'b0, fillNext};
            ladr[i] = fillAddr;
            fillValid = 1'b1;
            tick();
        end
        fillValid = 1'b0;
        stallMode = 1;
        tick();
        acc = 0;
        repeat (4) if (opReqReady === 1'b1) begin
            req(0);
            acc++;
        end
        opReqValid = 1'b0;
        `CHK("accepted", 2, acc)
        drain();
        repeat (10) req(int'(rnd() % 5));
        opReqValid = 1'b0;
        drain();
        stallMode = 0;
        tick();
        req(1);
        `CHK("opReqReady", 1'b1, opReqReady)
        req(2);
        opReqValid = 1'b0;
        drain();
        done("delivery");
        stallMode = 1;
        tick();
        req(0);
        opReqValid = 1'b0;
        r = rnd();
        mispValid = 1'b1;
        mispTarget = r;
        tick();
        mispValid = 1'b0;
        expQ.delete();
        `CHK("redirValid", 1'b1, redirValid)
        `CHK("redirAddr", r, redirAddr)
        `CHK("opValid", 1'b0, opValid)
        stallMode = 0;
        n = 0;
        while (opReqReady !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        `CHK("recovery", 32'(PEN_CYC), n)
        done("mispredict");
        // a low clock enable holds the lookup result
        clkEn = 1'b0;
        fetchValid = 1'b1;
        fetchAddr = {a[31:6], 6'h05};
        tick();
        `CHK("frozen", 1'b0, dynValid)
        clkEn = 1'b1;
        tick();
        fetchValid = 1'b0;
        `CHK("thawed", 1'b1, dynValid)
        done("freeze");
        summarize();
    end
endmodule
